// [verilog/tzs_regs.vh]
// Register offsets, field positions, reset values and timing constants for the thermal event logic
`ifndef TZS_REGS_VH
`define TZS_REGS_VH
`define TZS_ADDR_READING0 8'h00
`define TZS_ADDR_SETUP 8'h01
`define TZS_ADDR_RELEASE0 8'h02
`define TZS_ADDR_TRIP0 8'h03
`define TZS_ADDR_READING1 8'h10
`define TZS_ADDR_RELEASE1 8'h12
`define TZS_ADDR_TRIP1 8'h13
`define TZS_ADDR_READING2 8'h20
`define TZS_ADDR_RELEASE2 8'h22
`define TZS_ADDR_TRIP2 8'h23
`define TZS_SETUP_HALT 0
`define TZS_SETUP_MODE 1
`define TZS_SETUP_MASK 2
`define TZS_SETUP_FQ_LO 3
`define TZS_SETUP_FQ_HI 4
`define TZS_SETUP_FLAG2 5
`define TZS_SETUP_FLAG1 6
`define TZS_SETUP_FLAG0 7
`define TZS_RST_SETUP 5'h00
`define TZS_RST_READING 8'h00
`define TZS_RST_TRIP0 8'h51
`define TZS_RST_RELEASE0 8'h4C
`define TZS_RST_TRIP_REM 8'h61
`define TZS_RST_RELEASE_REM 8'h5C
`define TZS_FULL_SCALE 8'h7F
`define TZS_DEPTH_1 3'h1
`define TZS_DEPTH_2 3'h2
`define TZS_DEPTH_4 3'h4
`define TZS_DEPTH_6 3'h6
`define TZS_CONV_LOCAL_NS 100000
`define TZS_CLK_PERIOD_NS 10
`endif

// [verilog/tzs_event_logic.v]
// Three-zone thermal supervisor event logic: conversion sequencer, filters, flags, alert
//
// Operation
// - Readings are 8-bit two's complement, one degree per bit, bit 7 sign.
// - Conversions run back to back unless halted or a bus transaction is active.
// - Zone order after reset or halt exit: remote 1, remote 2, local; a transaction keeps the zone.
// - Remote zone conversion takes twice the local conversion time.
// - Interrupted conversion restarts from the start, then order continues.
// - Reset loads defaults; address-select pin sampled once after reset release.
// - Defaults: run, comparator, depth 00, unmasked, limits 81/76, 97/92.
// - After reset each zone is armed for an over-temperature event first.
// - Comparator mode: flag and alert follow trip/release with filter depth.
// - Comparator mode: halt leaves the alert level unchanged.
// - Interrupt mode: flag and alert clear only by host read or halt.
// - Interrupt mode: events alternate over and under per zone.
// - Halt bit stops conversions; registers stay accessible.
// - Halt in interrupt mode releases alert and clears all flags.
// - While halted no events and no sensor faults are detected.
// - Depth codes 00..11 need 1, 2, 4, 6 consecutive conversions, per zone.
// - Events always set flags; alert only drives with mask bit zero.
// - Any register read releases alert; only setup read clears flags.
// - Repeated events leave one set flag, not a count.
// - Mask bit one never sinks current on the alert pin.
// - Local events set flag 0, remote 1 flag 1, remote 2 flag 2.
// - Open or shorted remote sense sets its flag if trip below full scale.
// - Remote fault forces reading to +127 until the fault clears.
// - Halt 1 shutdown, mode 1 interrupt, mask 1 disables alert.
//
// The implementer's own choices: the strobed register port and the address map.
`default_nettype none
`include "tzs_regs.vh"
module tzs_event_logic #(
    parameter CONV_LOCAL_CYCLES = `TZS_CONV_LOCAL_NS / `TZS_CLK_PERIOD_NS
) (
    input wire clk_sys_in,
    input wire arst_n_in,
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire bus_busy_in,
    input wire addr_select_pin_in,
    input wire [7:0] adc_local_in,
    input wire [7:0] remote_sense_a_in,
    input wire [7:0] remote_sense_b_in,
    input wire remote_sense_a_fault_in,
    input wire remote_sense_b_fault_in,
    output reg [7:0] rdata_out,
    output reg addr_lsb_out,
    output reg alert_n_oe_out,
    output reg zone_sample_out
);
    // Zone codes double as array indices: local 0, remote 1, remote 2
    localparam ZONE_L0 = 2'h0;
    localparam ZONE_R1 = 2'h1;
    localparam ZONE_R2 = 2'h2;
    localparam CW = 24;
    localparam [CW-1:0] LOCAL_LEN = CONV_LOCAL_CYCLES;
    localparam [CW-1:0] REMOTE_LEN = CONV_LOCAL_CYCLES * 2;

    // Register map on the byte port
    //   00 local reading, read only
    //   01 setup, flags read only, low five bits read/write
    //   02 local release limit
    //   03 local trip limit
    //   10 remote 1 reading, read only
    //   12 remote 1 release limit
    //   13 remote 1 trip limit
    //   20 remote 2 reading, read only
    //   22 remote 2 release limit
    //   23 remote 2 trip limit
    //   Other offsets read as zero and ignore writes
    //
    // Setup byte
    //   bit 7 zone 0 flag, bit 6 zone 1 flag, bit 5 zone 2 flag
    //   bits 4:3 filter depth code, bit 2 alert mask
    //   bit 1 interrupt mode, bit 0 low-power halt
    //
    // Reset
    //   Running, comparator mode, depth code 00, unmasked,
    //   local limits 81/76, remote limits 97/92,
    //   every zone armed for an over-temperature event
    //
    // Timing
    //   Local conversion is CONV_LOCAL_CYCLES clocks, remote twice that,
    //   so one full round is five local periods. The result is taken
    //   in the last clock of a conversion; zone_sample_out pulses
    //   one clock later. Bus activity zeroes the timer but keeps the
    //   zone, so a cut conversion starts over once the bus is quiet.
    //
    // Alert path
    //   alert_q is the internal request; the pin enable follows one
    //   clock later and is forced off by the mask bit, so a polled
    //   system never sees the pin sink. Comparator mode recomputes
    //   alert_q from the active zones, so a read drops it for one
    //   clock, or until halt ends if halted. Interrupt mode latches it until a read or halt.
    //
    // Limitation: the address strap is caught once after reset;
    // moving the pin later has no effect until the next reset.

    // Setup fields
    reg halt_q;
    reg mode_q;
    reg alert_mask_bit_q;
    reg [1:0] filter_depth_field_q;
    reg [2:0] zone_flag_q;
    reg alert_q;
    reg [7:0] reading_q [0:2];
    reg [7:0] trip_q [0:2];
    reg [7:0] release_q [0:2];
    reg [2:0] cnt_q [0:2];
    reg [2:0] arm_over_q;
    reg [2:0] cmp_active_q;
    reg [1:0] zone_q;
    reg [CW-1:0] tick_q;
    reg strap_done_q;
    reg halt_prev_q;
    integer i;

    // Per-zone state
    //   cnt_q: qualifying conversions in the current run
    //   arm_over_q: interrupt mode, one while waiting for an over event
    //   cmp_active_q: comparator mode, one while past the trip limit
    // Counters keep their value across a halt, so a run cut by
    // shutdown goes on when conversions resume; this trades a
    // shorter filter delay after wake-up for fewer clear paths.

    // Filter depth code to number of consecutive conversions
    function [2:0] depth_of;
        input [1:0] code;
        begin
            case (code)
                2'h0: depth_of = `TZS_DEPTH_1;
                2'h1: depth_of = `TZS_DEPTH_2;
                2'h2: depth_of = `TZS_DEPTH_4;
                default: depth_of = `TZS_DEPTH_6;
            endcase
        end
    endfunction

    // Signed compare of two two's complement readings
    function gt_s;
        input [7:0] a;
        input [7:0] b;
        begin
            gt_s = $signed(a) > $signed(b);
        end
    endfunction

    // Next zone in the fixed order remote 1, remote 2, local
    function [1:0] next_zone;
        input [1:0] zone;
        begin
            case (zone)
                ZONE_R1: next_zone = ZONE_R2;
                ZONE_R2: next_zone = ZONE_L0;
                default: next_zone = ZONE_R1;
            endcase
        end
    endfunction

    // Above trip when watching for over, below release when watching for under
    function hits_limit;
        input look_over;
        input [7:0] s;
        input [7:0] trip;
        input [7:0] rel;
        begin
            if (look_over) begin
                hits_limit = gt_s(s, trip);
            end else begin
                hits_limit = gt_s(rel, s);
            end
        end
    endfunction

    // True when this qualifying conversion completes the run
    function filter_full;
        input [2:0] count;
        input [2:0] need;
        begin
            filter_full = (count + 3'h1) >= need;
        end
    endfunction

    wire [CW-1:0] conv_len = (zone_q == ZONE_L0) ? LOCAL_LEN : REMOTE_LEN;
    wire conv_done = !halt_q && !bus_busy_in && (tick_q == conv_len - 24'h000001);
    // Input of the zone now converting; a fault reads as full scale
    reg sel_fault;
    reg [7:0] raw;
    always @* begin
        sel_fault = 1'b0;
        raw = adc_local_in;
        case (zone_q)
            ZONE_R1: begin
                sel_fault = remote_sense_a_fault_in;
                raw = remote_sense_a_in;
            end
            ZONE_R2: begin
                sel_fault = remote_sense_b_fault_in;
                raw = remote_sense_b_in;
            end
            default: begin
                sel_fault = 1'b0;
                raw = adc_local_in;
            end
        endcase
    end

    wire [7:0] sample = sel_fault ? `TZS_FULL_SCALE : raw;
    wire [2:0] depth = depth_of(filter_depth_field_q);
    wire setup_rd = rd_in && (addr_in == `TZS_ADDR_SETUP);
    wire halt_enter = halt_q && !halt_prev_q;

    // Conversion sequencer
    // Halt parks the sequence on remote 1, so the first result after
    // wake-up is always the first remote zone. Bus activity only
    // zeroes the timer: the zone is kept and runs again in full.
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            zone_q <= ZONE_R1;
            tick_q <= {CW{1'b0}};
            halt_prev_q <= 1'b0;
            zone_sample_out <= 1'b0;
        end else begin
            halt_prev_q <= halt_q;
            zone_sample_out <= conv_done;
            if (halt_q) begin
                zone_q <= ZONE_R1;
                tick_q <= {CW{1'b0}};
            end else if (bus_busy_in) begin
                tick_q <= {CW{1'b0}};
            end else if (conv_done) begin
                tick_q <= {CW{1'b0}};
                zone_q <= next_zone(zone_q);
            end else begin
                tick_q <= tick_q + 24'h000001;
            end
        end
    end

    // Address strap caught once after reset release
    // The pin is meant to be tied off; ignoring later changes keeps
    // the bus address steady for the whole run.
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            strap_done_q <= 1'b0;
            addr_lsb_out <= 1'b0;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            addr_lsb_out <= addr_select_pin_in;
        end
    end

    // Registers, filters, flags and alert
    // Order matters: later assignments win, so a qualified event beats
    // a flag clear from a read in the same clock and no event is lost
    // to a badly timed host poll.
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            {filter_depth_field_q, alert_mask_bit_q, mode_q, halt_q} <= `TZS_RST_SETUP;
            zone_flag_q <= 3'h0;
            alert_q <= 1'b0;
            arm_over_q <= 3'h7;
            cmp_active_q <= 3'h0;
            trip_q[0] <= `TZS_RST_TRIP0;
            release_q[0] <= `TZS_RST_RELEASE0;
            for (i = 1; i < 3; i = i + 1) begin
                trip_q[i] <= `TZS_RST_TRIP_REM;
                release_q[i] <= `TZS_RST_RELEASE_REM;
            end
            for (i = 0; i < 3; i = i + 1) begin
                reading_q[i] <= `TZS_RST_READING;
                cnt_q[i] <= 3'h0;
            end
            rdata_out <= 8'h00;
            alert_n_oe_out <= 1'b1;
        end else begin
            // Host reads: alert released by any read, flags by setup read only
            if (rd_in) begin
                alert_q <= 1'b0;
            end
            if (setup_rd && mode_q) begin
                zone_flag_q <= 3'h0;
            end
            if (setup_rd && !mode_q) begin
                zone_flag_q <= cmp_active_q;
            end
            // Writes; reading registers are read only
            if (wr_in) begin
                case (addr_in)
                    `TZS_ADDR_SETUP: begin
                        halt_q <= wdata_in[`TZS_SETUP_HALT];
                        mode_q <= wdata_in[`TZS_SETUP_MODE];
                        alert_mask_bit_q <= wdata_in[`TZS_SETUP_MASK];
                        filter_depth_field_q <= wdata_in[`TZS_SETUP_FQ_HI:`TZS_SETUP_FQ_LO];
                    end
                    `TZS_ADDR_RELEASE0: release_q[0] <= wdata_in;
                    `TZS_ADDR_TRIP0: trip_q[0] <= wdata_in;
                    `TZS_ADDR_RELEASE1: release_q[1] <= wdata_in;
                    `TZS_ADDR_TRIP1: trip_q[1] <= wdata_in;
                    `TZS_ADDR_RELEASE2: release_q[2] <= wdata_in;
                    `TZS_ADDR_TRIP2: trip_q[2] <= wdata_in;
                    default: ;
                endcase
            end
            // Halt in interrupt mode drops latched state; comparator keeps alert level
            if (halt_enter && mode_q) begin
                zone_flag_q <= 3'h0;
                alert_q <= 1'b0;
            end
            // Conversion result: store, filter, raise events (never while halted)
            // A remote fault runs through the same filter, so it flags only
            // when that zone's trip limit is below full scale
            if (conv_done) begin
                reading_q[zone_q] <= sample;
                if (mode_q) begin
                    // Count toward the armed direction only
                    if (hits_limit(arm_over_q[zone_q], sample, trip_q[zone_q], release_q[zone_q])) begin
                        if (filter_full(cnt_q[zone_q], depth)) begin
                            cnt_q[zone_q] <= 3'h0;
                            arm_over_q[zone_q] <= !arm_over_q[zone_q];
                            zone_flag_q[zone_q] <= 1'b1;
                            alert_q <= 1'b1;
                        end else begin
                            cnt_q[zone_q] <= cnt_q[zone_q] + 3'h1;
                        end
                    end else begin
                        cnt_q[zone_q] <= 3'h0;
                    end
                end else begin
                    // Comparator: active state follows filtered trip/release
                    if (hits_limit(!cmp_active_q[zone_q], sample, trip_q[zone_q], release_q[zone_q])) begin
                        if (filter_full(cnt_q[zone_q], depth)) begin
                            cnt_q[zone_q] <= 3'h0;
                            cmp_active_q[zone_q] <= !cmp_active_q[zone_q];
                            zone_flag_q[zone_q] <= !cmp_active_q[zone_q];
                            arm_over_q[zone_q] <= cmp_active_q[zone_q];
                        end else begin
                            cnt_q[zone_q] <= cnt_q[zone_q] + 3'h1;
                        end
                    end else begin
                        cnt_q[zone_q] <= 3'h0;
                    end
                end
            end
            // Comparator alert tracks active zones; frozen while halted
            // A read lets the release above stand for one clock, or until halt ends if halted
            if (!mode_q && !halt_q && !rd_in) begin
                alert_q <= |cmp_active_q;
            end
            // Alert pin sinks only when unmasked; enable is low while driving
            alert_n_oe_out <= !(alert_q && !alert_mask_bit_q);
            // Registered read data, one cycle after the strobe
            case (addr_in)
                `TZS_ADDR_READING0: rdata_out <= reading_q[0];
                `TZS_ADDR_SETUP: rdata_out <= {zone_flag_q[0], zone_flag_q[1], zone_flag_q[2],
                                               filter_depth_field_q, alert_mask_bit_q, mode_q, halt_q};
                `TZS_ADDR_RELEASE0: rdata_out <= release_q[0];
                `TZS_ADDR_TRIP0: rdata_out <= trip_q[0];
                `TZS_ADDR_READING1: rdata_out <= reading_q[1];
                `TZS_ADDR_RELEASE1: rdata_out <= release_q[1];
                `TZS_ADDR_TRIP1: rdata_out <= trip_q[1];
                `TZS_ADDR_READING2: rdata_out <= reading_q[2];
                `TZS_ADDR_RELEASE2: rdata_out <= release_q[2];
                `TZS_ADDR_TRIP2: rdata_out <= trip_q[2];
                default: rdata_out <= 8'h00;
            endcase
        end
    end
endmodule
`default_nettype wire

// [sim/tzs_event_logic_properties.sv]
// Port-level checker for the thermal event logic
`default_nettype none
module tzs_event_checker (
    input wire clk_sys_in,
    input wire arst_n_in,
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire bus_busy_in,
    input wire [7:0] rdata_out,
    input wire addr_lsb_out,
    input wire alert_n_oe_out,
    input wire zone_sample_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic halt_q, mode_q, mask_q;
    logic [7:0] trip0_q;
    logic [1:0] up_q;
    wire setup_wr = wr_in && addr_in == 8'h01;
    // Shadow of setup and local trip writes, so bus traffic explains the outputs
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            {mask_q, mode_q, halt_q} <= 3'h0;
            trip0_q <= 8'h51;
            up_q <= 2'h0;
        end else begin
            if (setup_wr) {mask_q, mode_q, halt_q} <= wdata_in[2:0];
            if (wr_in && addr_in == 8'h03) trip0_q <= wdata_in;
            up_q <= {up_q[0], 1'b1};
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!arst_n_in);
    // A fresh sample may legally re-assert, so those cycles are excluded
    AST_READ_RELEASE: assert property (!zone_sample_out && rd_in ##1 !zone_sample_out[*2] |-> alert_n_oe_out)
        else $error("alert held after a read");
    AST_MASK_SILENT: assert property (mask_q[*2] |-> alert_n_oe_out)
        else $error("alert sinks while masked");
    AST_HALT_IDLE: assert property (halt_q[*2] |-> !zone_sample_out)
        else $error("conversion while halted");
    AST_BUSY_IDLE: assert property (bus_busy_in[*2] |=> !zone_sample_out)
        else $error("conversion during bus transaction");
    AST_SAMPLE_GAP: assert property (zone_sample_out |=> !zone_sample_out[*3])
        else $error("conversion shorter than local time");
    AST_STRAP_HELD: assert property (up_q[1] |-> $stable(addr_lsb_out))
        else $error("address strap changed");
    AST_TRIP_READBACK: assert property (rd_in && addr_in == 8'h03 |=> rdata_out == $past(trip0_q))
        else $error("trip limit readback wrong");
    AST_HALT_INT_CLEAR: assert property (setup_wr && wdata_in[1:0] == 2'h3 |-> ##3 alert_n_oe_out)
        else $error("alert kept after halt in interrupt mode");
    AST_CMP_FREEZE: assert property ((halt_q && !mode_q && !rd_in && !wr_in)[*5] |=> $stable(alert_n_oe_out))
        else $error("alert moved while halted");
endmodule
`default_nettype wire

// [sim/tzs_host_model.sv]
// Host side of the register port: byte writes, byte reads, serial busy spans
`default_nettype none
module tzs_host_model (
    input wire logic clk_sys_in,
    input wire logic [7:0] rdata_in,
    output logic [7:0] addr_out,
    output logic [7:0] wdata_out,
    output logic wr_out,
    output logic rd_out,
    output logic busy_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {addr_out, wdata_out} = 16'h0000;
        {wr_out, rd_out, busy_out} = 3'h0;
    end
    // Data is scrambled once taken, so nothing can lean on a stale byte
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_sys_in);
        wr_out <= 1'b0;
        wdata_out <= ~d;
    endtask
    // Read data is taken in the cycle after the strobe; it then tracks the held address
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_sys_in);
        rd_out <= 1'b0;
        #1 d = rdata_in;
    endtask
    task automatic busy(input int n);
        @(posedge clk_sys_in);
        busy_out <= 1'b1;
        repeat (n) @(posedge clk_sys_in);
        busy_out <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the thermal event logic
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic strap = 1'b1;
    logic [7:0] t_loc = 8'h19, t_ra = 8'h19, t_rb = 8'hD8;
    logic f_a = 1'b0, f_b = 1'b0;
    logic [7:0] addr, wdata, rdata, v;
    logic wr, rd, busy, lsb, al, zs;
    int fail_count = 0;
    int tests_run = 0;
    always #5 clk_sys_in = ~clk_sys_in;
    tzs_host_model u_tzs_host_model (.clk_sys_in(clk_sys_in), .rdata_in(rdata), .addr_out(addr),
        .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .busy_out(busy));
    tzs_event_logic #(.CONV_LOCAL_CYCLES(4)) u_tzs_event_logic (.clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .bus_busy_in(busy), .addr_select_pin_in(strap), .adc_local_in(t_loc), .remote_sense_a_in(t_ra),
        .remote_sense_b_in(t_rb), .remote_sense_a_fault_in(f_a), .remote_sense_b_fault_in(f_b),
        .rdata_out(rdata), .addr_lsb_out(lsb), .alert_n_oe_out(al), .zone_sample_out(zs));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        u_tzs_host_model.read_reg(a, v);
        check(v, e);
    endtask
    task automatic do_reset();
        arst_n_in <= 1'b0;
        cyc(5);
        arst_n_in <= 1'b1;
    endtask
    // Bounded wait for the next conversion pulse; the count is the spacing
    task automatic wait_zs(output int n);
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (zs !== 1'b1 && n < 40);
        if (n >= 40) begin
            fail_count++;
            $display("[ERR] %0t no conversion seen", $time);
            report_and_stop();
        end
    endtask
    task automatic t_defaults();
        logic [7:0] ad [6] = '{8'h02, 8'h03, 8'h12, 8'h13, 8'h22, 8'h23};
        logic [7:0] ex [6] = '{8'h4C, 8'h51, 8'h5C, 8'h61, 8'h5C, 8'h61};
        for (int i = 0; i < 6; i++) rd_chk(ad[i], ex[i]);
        check({7'h00, lsb}, 8'h01);
        rd_chk(8'h05, 8'h00);
        cyc(25);
        rd_chk(8'h20, 8'hD8);
        rd_chk(8'h01, 8'h00);
        $display("defaults done");
    endtask
    task automatic t_order();
        int g [4];
        u_tzs_host_model.write_reg(8'h01, 8'h01);
        cyc(10);
        u_tzs_host_model.write_reg(8'h01, 8'h00);
        for (int i = 0; i < 4; i++) wait_zs(g[i]);
        check(8'(g[1]), 8'h08);
        check(8'(g[2]), 8'h04);
        check(8'(g[3]), 8'h08);
        $display("order done");
    endtask
    task automatic t_busy();
        int n, g;
        u_tzs_host_model.write_reg(8'h01, 8'h01);
        u_tzs_host_model.write_reg(8'h01, 8'h00);
        wait_zs(n);
        cyc(3);
        u_tzs_host_model.busy(20);
        wait_zs(n);
        wait_zs(g);
        check(8'(n > 7), 8'h01);
        check(8'(g), 8'h04);
        $display("busy done");
    endtask
    // Each depth code: no alert one local conversion early, alert on time
    task automatic t_filter();
        int dp [4] = '{1, 2, 4, 6};
        for (int c = 0; c < 4; c++) begin
            do_reset();
            u_tzs_host_model.write_reg(8'h01, 8'(c << 3));
            t_loc <= 8'h60;
            cyc(20 * dp[c] - 8);
            check({7'h00, al}, 8'h01);
            cyc(16);
            check({7'h00, al}, 8'h00);
        end
        rd_chk(8'h01, 8'h98);
        t_loc <= 8'h40;
        cyc(132);
        check({7'h00, al}, 8'h01);
        rd_chk(8'h01, 8'h18);
        $display("filter done");
    endtask
    task automatic t_interrupt();
        do_reset();
        u_tzs_host_model.write_reg(8'h01, 8'h02);
        t_loc <= 8'h60;
        cyc(60);
        check({7'h00, al}, 8'h00);
        rd_chk(8'h00, 8'h60);
        cyc(41);
        check({7'h00, al}, 8'h01);
        rd_chk(8'h01, 8'h82);
        rd_chk(8'h01, 8'h02);
        t_loc <= 8'h19;
        cyc(25);
        check({7'h00, al}, 8'h00);
        u_tzs_host_model.write_reg(8'h01, 8'h03);
        cyc(3);
        check({7'h00, al}, 8'h01);
        rd_chk(8'h01, 8'h03);
        $display("interrupt done");
    endtask
    task automatic t_mask_fault();
        do_reset();
        u_tzs_host_model.write_reg(8'h01, 8'h04);
        t_loc <= 8'h60;
        cyc(30);
        check({7'h00, al}, 8'h01);
        rd_chk(8'h01, 8'h84);
        strap <= 1'b0;
        do_reset();
        t_loc <= 8'h19;
        f_a <= 1'b1;
        cyc(25);
        strap <= 1'b1;
        check({7'h00, al}, 8'h00);
        rd_chk(8'h10, 8'h7F);
        rd_chk(8'h01, 8'h40);
        u_tzs_host_model.write_reg(8'h01, 8'h01);
        u_tzs_host_model.write_reg(8'h03, 8'h55);
        cyc(6);
        check({7'h00, al}, 8'h00);
        rd_chk(8'h03, 8'h55);
        check({7'h00, lsb}, 8'h00);
        u_tzs_host_model.write_reg(8'h01, 8'h00);
        f_a <= 1'b0;
        cyc(25);
        rd_chk(8'h10, 8'h19);
        $display("mask and fault done");
    endtask
    initial begin
        cyc(5);
        arst_n_in <= 1'b1;
        t_defaults();
        t_order();
        t_busy();
        t_filter();
        t_interrupt();
        t_mask_fault();
        report_and_stop();
    end
endmodule
bind tzs_event_logic tzs_event_checker u_tzs_event_checker (.clk_sys_in, .arst_n_in, .addr_in,
    .wdata_in, .wr_in, .rd_in, .bus_busy_in, .rdata_out, .addr_lsb_out, .alert_n_oe_out, .zone_sample_out);
`default_nettype wire
